/* logic/pwm_time_base_params.svh */
// Purpose: Offsets, field positions, reset values and counts of the PWM time base.
// Assumes: Included by the package and the testbench.
// Notes: Byte offsets on the AHB-Lite register bus.
`ifndef PWM_TIME_BASE_PARAMS_SVH
`define PWM_TIME_BASE_PARAMS_SVH

`define OFS_CONTROL 8'h00
`define OFS_COUNT 8'h04
`define OFS_PERIOD 8'h08
`define OFS_IRQ_STATUS 8'h0C
`define OFS_IRQ_MASK 8'h10

`define CTL_ON_BIT 15
`define CTL_POST_LSB 4
`define CTL_PRE_LSB 2
`define CTL_MODE_LSB 0
`define CNT_DIR_BIT 15

`define MODE_FREE 2'h0
`define MODE_SINGLE 2'h1
`define MODE_UPDOWN 2'h2
`define MODE_DOUBLE 2'h3

`define PRE_LIM_1 6'h00
`define PRE_LIM_4 6'h03
`define PRE_LIM_16 6'h0F
`define PRE_LIM_64 6'h3F

`define RST_COUNT 15'h0000
`define RST_PERIOD 15'h0000
`define RST_CTL 16'h0000
`define RST_IRQ 1'h0

`endif

/* logic/pwm_time_base_pkg.sv */
// Purpose: Types shared by the PWM time base.
// Assumes: Constants come from the params header.
// Notes: Mode codes are the two-bit mode select values.
`include "pwm_time_base_params.svh"

package pwm_time_base_pkg;

  typedef enum logic [1:0] {
    MODE_FREE = `MODE_FREE,
    MODE_SINGLE = `MODE_SINGLE,
    MODE_UPDOWN = `MODE_UPDOWN,
    MODE_DOUBLE = `MODE_DOUBLE
  } tb_mode_t;

  typedef struct packed {
    logic on;
    logic [3:0] post_sel;
    logic [1:0] pre_sel;
    tb_mode_t mode;
  } ctl_t;

  typedef struct packed {
    ctl_t ctl;
    logic [14:0] count;
    logic dir;
    logic [14:0] per_buf;
    logic [14:0] per_act;
    logic [5:0] presc;
    logic [3:0] post;
    logic event_p;
    logic stat;
    logic mask;
    logic a_sel;
    logic a_write;
    logic [7:0] a_addr;
    logic [31:0] rdata;
  } state_t;

endpackage : pwm_time_base_pkg

/* logic/pwm_time_base.sv */
// Purpose: PWM time base with prescaler, postscaler, period and four count modes.
// Assumes: Single AHB-Lite slave, zero wait states, OKAY responses only.
// Notes: All state lives in one packed struct registered in one process.
//   Register map, one word each: control, count, period buffer, status, mask.
//   Control holds the enable in bit 15, postscale in 7:4, prescale in 3:2, mode in 1:0.
//   Count holds the value in 14:0 and the read-only direction in bit 15.
//   Status bit 0 is set by each event and cleared by writing a one.
//   Only address bits 7:2 are decoded, so the map repeats every 256 bytes.
`timescale 1ns/1ps

// Functional notes
// - 15-bit counter behind a prescaler, postscaled match, count register readable and writable.
// - Count bit 15 reads the direction, one while counting down.
// - Time base on runs the counter; clearing it keeps the count.
// - Count equal to period resets or reverses on the next counter clock.
// - Zero period stops counting and suppresses all events.
// - A zero active period is never reloaded while the time base runs.
// - Mode select: 00 free, 01 single-shot, 10 up/down, 11 double update.
// - Free mode counts up, resets to zero after match, repeats while on.
// - Free mode raises a postscaled event at each match reset.
// - Single-shot counts up, resets after match and hardware clears time base on.
// - Single-shot raises one event at that reset, postscaler ignored.
// - Up/down modes count up to match, then down, direction flag set.
// - Mode 10 raises a postscaled event when count reaches zero and turns up.
// - Event generation depends on mode select, and on postscale select in modes 00 and 10 only.
// - Mode 11 raises events at zero and at period match, postscaler ignored.
// - Prescale 1, 4, 16 or 64; cleared by count or control writes and reset.
// - Postscale 1 to 16; cleared by count or control writes and reset.
// - Period double-buffered, loaded at the mode's reload instant or when disabled.
module pwm_time_base
  import pwm_time_base_pkg::*;
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Time-base status and events.
  output logic count_down_flag,
  output logic tb_event,
  output logic irq
);

  state_t q;
  state_t d;

  // Reset image of the whole state, built from the reset values.
  localparam state_t rst_state = '{
    ctl: '{on: 1'b0, post_sel: 4'h0, pre_sel: 2'h0, mode: MODE_FREE},
    count: `RST_COUNT,
    dir: 1'b0,
    per_buf: `RST_PERIOD,
    per_act: `RST_PERIOD,
    presc: 6'h00,
    post: 4'h0,
    event_p: `RST_IRQ,
    stat: `RST_IRQ,
    mask: `RST_IRQ,
    a_sel: 1'b0,
    a_write: 1'b0,
    a_addr: 8'h00,
    rdata: 32'h0000_0000
  };

  // Terminal count of the prescaler for each selection.
  function automatic logic [5:0] pre_limit(input logic [1:0] sel);
    logic [5:0] lim;
    lim = `PRE_LIM_1;
    unique case (sel)
      2'h0: lim = `PRE_LIM_1;
      2'h1: lim = `PRE_LIM_4;
      2'h2: lim = `PRE_LIM_16;
      2'h3: lim = `PRE_LIM_64;
    endcase
    return lim;
  endfunction : pre_limit

  // Both up/down modes share the turn-around and zero-event logic.
  function automatic logic is_updown(input tb_mode_t m);
    return (m == MODE_UPDOWN) || (m == MODE_DOUBLE);
  endfunction : is_updown

  // Next count one step up or down; the counter wraps within its 15 bits.
  function automatic logic [14:0] count_step(input logic [14:0] c, input logic down);
    logic [14:0] n;
    n = down ? c - 15'h0001 : c + 15'h0001;
    return n;
  endfunction : count_step

  // True in the data phase of a write to the register at the given offset.
  function automatic logic wr_hit(input state_t s, input logic [7:0] ofs);
    return s.a_sel && s.a_write && (s.a_addr == ofs);
  endfunction : wr_hit

  // Control fields as they sit in a written word.
  function automatic ctl_t ctl_from_word(input logic [31:0] w);
    ctl_t c;
    c.on = w[`CTL_ON_BIT];
    c.post_sel = w[`CTL_POST_LSB +: 4];
    c.pre_sel = w[`CTL_PRE_LSB +: 2];
    c.mode = tb_mode_t'(w[`CTL_MODE_LSB +: 2]);
    return c;
  endfunction : ctl_from_word

  // Control fields placed in a read word; unused bits read as zero.
  function automatic logic [31:0] ctl_to_word(input ctl_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CTL_ON_BIT] = c.on;
    w[`CTL_POST_LSB +: 4] = c.post_sel;
    w[`CTL_PRE_LSB +: 2] = c.pre_sel;
    w[`CTL_MODE_LSB +: 2] = c.mode;
    return w;
  endfunction : ctl_to_word

  // Count word: the value in the low bits and the direction on top.
  function automatic logic [31:0] count_word(input logic [14:0] c, input logic down);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[14:0] = c;
    w[`CNT_DIR_BIT] = down;
    return w;
  endfunction : count_word

  // Read value of a register in a given state.
  function automatic logic [31:0] read_reg(input state_t s, input logic [7:0] addr);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (addr)
      `OFS_CONTROL: begin
        r = ctl_to_word(s.ctl);
      end
      `OFS_COUNT: begin
        r = count_word(s.count, s.dir);
      end
      `OFS_PERIOD: begin
        r[14:0] = s.per_buf;
      end
      `OFS_IRQ_STATUS: begin
        r[0] = s.stat;
      end
      `OFS_IRQ_MASK: begin
        r[0] = s.mask;
      end
      default: begin
        r = 32'h0000_0000;
      end
    endcase
    return r;
  endfunction : read_reg

  logic tick;
  logic running;
  logic match;
  logic raw_post;
  logic direct_ev;
  logic post_ev;
  logic reload;
  logic wr_ctl;
  logic wr_cnt;
  logic wr_per;
  logic wr_stat;
  logic wr_mask;
  logic down_now;
  logic addr_go;
  logic [7:0] addr_word;

  always_comb begin
    d = q;
    d.event_p = 1'b0;
    tick = 1'b0;
    match = 1'b0;
    raw_post = 1'b0;
    direct_ev = 1'b0;
    post_ev = 1'b0;
    reload = 1'b0;
    down_now = 1'b0;
    addr_go = 1'b0;
    addr_word = 8'h00;

    // Data-phase write decode.
    wr_ctl = wr_hit(q, `OFS_CONTROL);
    wr_cnt = wr_hit(q, `OFS_COUNT);
    wr_per = wr_hit(q, `OFS_PERIOD);
    wr_stat = wr_hit(q, `OFS_IRQ_STATUS);
    wr_mask = wr_hit(q, `OFS_IRQ_MASK);

    // The prescaler and counter stand still unless enabled with a nonzero
    // active period.
    // run gate
    running = q.ctl.on && (q.per_act != 15'h0000);

    // Free-running and single-shot only ever count up. A direction left
    // over from an up/down run is dropped here, so that a mode change made
    // while descending cannot leave the counter walking down past zero.
    down_now = q.dir && is_updown(q.ctl.mode);
    if (!is_updown(q.ctl.mode)) begin
      d.dir = 1'b0;
    end

    if (running) begin
      if (q.presc == pre_limit(q.ctl.pre_sel)) begin
        d.presc = 6'h00;
        tick = 1'b1;
      end else begin
        d.presc = q.presc + 6'h01;
      end
    end

    // A period of one in double-update mode gives events on two ticks of every three;
    // software is expected to avoid it.
    // period compare
    match = (q.count == q.per_act);

    if (tick) begin
      if (!down_now) begin
        if (match) begin
          unique case (q.ctl.mode)
            MODE_FREE: begin
              d.count = 15'h0000;
              raw_post = 1'b1;
              reload = 1'b1;
            end
            MODE_SINGLE: begin
              d.count = 15'h0000;
              d.ctl.on = 1'b0;
              direct_ev = 1'b1;
              reload = 1'b1;
            end
            MODE_UPDOWN: begin
              d.dir = 1'b1;
              d.count = count_step(q.count, 1'b1);
            end
            MODE_DOUBLE: begin
              d.dir = 1'b1;
              d.count = count_step(q.count, 1'b1);
              direct_ev = 1'b1;
            end
          endcase
        end else begin
          d.count = count_step(q.count, 1'b0);
        end
      end else begin
        if (q.count <= 15'h0001) begin
          // Reaching zero turns the counter upward. A step from one lands on
          // zero and turns in the same tick, so zero is held for one tick.
          d.count = 15'h0000;
          d.dir = 1'b0;
          reload = 1'b1;
          if (q.ctl.mode == MODE_DOUBLE) begin
            direct_ev = 1'b1;
          end else begin
            raw_post = 1'b1;
          end
        end else begin
          d.count = count_step(q.count, 1'b1);
        end
      end
    end

    // Free-running and mode 10 events are thinned here; single-shot and
    // double-update events bypass the postscaler.
    // postscaler divide
    if (raw_post) begin
      if (q.post == q.ctl.post_sel) begin
        d.post = 4'h0;
        post_ev = 1'b1;
      end else begin
        d.post = q.post + 4'h1;
      end
    end

    d.event_p = direct_ev || post_ev;

    // While the time base is off the buffer copies through every cycle, so
    // the first period after enabling is always the newest one written.
    // period reload
    if (!q.ctl.on || (reload && (q.per_act != 15'h0000))) begin
      d.per_act = q.per_buf;
    end

    // Software writes take effect after the counter step, so a count or
    // control write wins a tie with the hardware, the single-shot clear of
    // the enable included.
    if (wr_ctl) begin
      d.ctl = ctl_from_word(hwdata);
    end
    if (wr_cnt) begin
      d.count = hwdata[14:0];
    end
    if (wr_ctl || wr_cnt) begin
      d.presc = 6'h00;
      d.post = 4'h0;
    end
    if (wr_per) begin
      d.per_buf = hwdata[14:0];
    end
    if (wr_mask) begin
      d.mask = hwdata[0];
    end

    // Events keep setting status while masked, so unmasking later still
    // reports them on the interrupt line.
    // A new event wins over a simultaneous write-one clear.
    d.stat = (q.stat && !(wr_stat && hwdata[0])) || d.event_p;

    // Address phase capture. Read data is taken from the next state, so a
    // read right behind a write to the same register already sees the new
    // value. A write leaves the read data alone, which keeps it standing
    // until the next read is taken. An idle cycle with hready high ends
    // the data phase; with hready low the previous capture is kept.
    addr_go = hsel && hready && htrans[1];
    addr_word = {haddr[7:2], 2'b00};
    if (addr_go) begin
      d.a_sel = 1'b1;
      d.a_write = hwrite;
      d.a_addr = addr_word;
      if (!hwrite) begin
        d.rdata = read_reg(d, addr_word);
      end
    end else if (hready) begin
      d.a_sel = 1'b0;
      d.a_write = 1'b0;
    end
  end

  // Asynchronous reset loads the reset image; nothing else is gated.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= rst_state;
    end else begin
      q <= d;
    end
  end

  // The slave never stretches a transfer and always answers OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign count_down_flag = q.dir;
  assign tb_event = q.event_p;
  assign irq = q.stat && q.mask;

endmodule : pwm_time_base

/* verification/pwm_time_base_properties.sv */
// Purpose: Port checks of the PWM time base.
// Assumes: Bound to every pwm_time_base instance.
// Notes: Watches top-level ports only.
`timescale 1ns/1ps
module pwm_time_base_chk (
  // Clock, reset and bus.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Time base.
  input wire logic count_down_flag,
  input wire logic tb_event,
  input wire logic irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_go, wr_go, um_go;
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  assign wr_go = hsel && hready && htrans[1] && hwrite;
  assign um_go = rd_go && haddr[7:2] > 6'h04;
  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer");
  AST_PULSE: assert property (tb_event |=> !tb_event)
    else $error("event pulse");
  AST_RDHOLD: assert property (!$past(rd_go) |-> $stable(hrdata))
    else $error("read data hold");
  AST_UPPER: assert property ($past(rd_go) |-> hrdata[31:16] == 16'h0000)
    else $error("upper bits");
  AST_UNMAP: assert property ($past(um_go) |-> hrdata == 32'h0000_0000)
    else $error("unmapped read");
  AST_IRQ_SET: assert property ($rose(irq) |-> tb_event || $past(wr_go, 2))
    else $error("irq rise");
  AST_IRQ_CLR: assert property ($fell(irq) |-> $past(wr_go, 2))
    else $error("irq fall");
  AST_RESET: assert property ($rose(hresetn) |-> !tb_event && !irq && !count_down_flag)
    else $error("reset state");
  cover property (tb_event);
  cover property ($rose(count_down_flag));
  cover property ($fell(irq));
endmodule : pwm_time_base_chk

bind pwm_time_base pwm_time_base_chk chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .count_down_flag, .tb_event, .irq);

/* verification/pwm_time_base_tb.sv */
// Purpose: Self-checking bench for the PWM time base.
// Assumes: Zero-wait AHB-Lite slave.
// Notes: Event gaps are timed over one full period pair.
`timescale 1ns/1ps
`include "pwm_time_base_params.svh"
module pwm_time_base_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, count_down_flag, tb_event, irq;
  int seed = 32'hD72C, bad_count = 0, n_checks = 0, k, p, o, t, a;
  int md[4] = '{0, 2, 3, 2};
  always #25 hclk = ~hclk;
  pwm_time_base dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .count_down_flag,
    .tb_event, .irq);
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic hang;
    bad_count++;
    final_report();
  endtask : hang
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, ad};
    hwrite <= w;
    do @(posedge hclk); while (!hreadyout && ++n < 9);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout && ++n < 9);
    if (n >= 9) hang();
    rd = hrdata;
  endtask : bus
  // Counts cycles up to and including the next event.
  task automatic ev(output int c);
    c = 1;
    do @(negedge hclk); while (!tb_event && ++c < 30000);
    if (c >= 30000) hang();
  endtask : ev
  task automatic quiet;
    t = 0;
    repeat (300) @(negedge hclk) t += tb_event;
    chk("no events", 0, t);
  endtask : quiet
  function automatic int gap(int m, int p, int d, int o);
    if (m == 0) return 2 * (p + 1) * d * (o + 1);
    if (m == 2) return 4 * p * d * (o + 1);
    return 2 * p * d;
  endfunction : gap
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (k = 0; k < 24; k += 4) begin
      bus(0, k[7:0], 0);
      chk("reset read", 0, rd);
    end
    bus(1, `OFS_IRQ_MASK, 1);
    for (k = 0; k < 4; k++) begin
      p = 2 + {$random(seed)} % 8;
      o = {$random(seed)} % 4;
      bus(1, `OFS_COUNT, 0);
      bus(1, `OFS_PERIOD, p);
      bus(1, `OFS_CONTROL, 32'h8000 | o << 4 | k << 2 | md[k]);
      ev(t);
      ev(t);
      ev(a);
      chk("event gap", gap(md[k], p, 1 << 2 * k, o), t + a);
      chk("irq", 1, irq);
      chk("down flag", md[k] == 3 && a > t, count_down_flag);
      bus(1, `OFS_CONTROL, 0);
      bus(0, `OFS_COUNT, 0);
      t = rd;
      repeat (20) @(posedge hclk);
      bus(0, `OFS_COUNT, 0);
      chk("held count", t, rd);
      bus(1, `OFS_IRQ_STATUS, 1);
      @(negedge hclk);
      chk("irq clear", 0, irq);
    end
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, `OFS_COUNT, 0);
    chk("reset count", 0, rd);
    bus(1, `OFS_PERIOD, 2 + {$random(seed)} % 8);
    bus(1, `OFS_CONTROL, 32'h8001);
    ev(t);
    bus(0, `OFS_CONTROL, 0);
    chk("shot off", 32'h1, rd);
    bus(0, `OFS_COUNT, 0);
    chk("shot count", 0, rd);
    quiet();
    bus(1, `OFS_PERIOD, 0);
    bus(1, `OFS_CONTROL, 32'h8000);
    bus(1, `OFS_PERIOD, 5);
    quiet();
    final_report();
  end
endmodule : pwm_time_base_tb
